// ===== rtl/gpc_ctrl.sv
// bus controller: wishbone registers in, active-low instrument bus pins out
// Contract
// - uniline commands go out only by driving their own line true.
// - attention, interface clear and remote enable are driven by the controller alone.
// - sender asserts end-or-identify together with the last byte.
// - attention held true around address and command bytes; such bytes are commands.
// - listen address byte is primary address ORed with 20 hex.
// - talk address byte is primary address ORed with 40 hex.
// - common and instrument text travels as data bytes with attention false.
// - every bus line is active low.
// - each byte moves by interlocked handshake; valid only after all ready.
`timescale 1ns/10ps
`default_nettype none
`include "gpc_cfg.svh"
module gpc_ctrl #(
  parameter int unsigned IFC_NS = `GPC_T_IFC_NS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [7:0]  dio_n_i,
  output logic      [7:0]  dio_n_o,
  output logic             dio_oe_o,
  input  wire logic        eoi_n_i,
  output logic             eoi_n_o,
  output logic             eoi_oe_o,
  input  wire logic        dav_n_i,
  output logic             dav_n_o,
  output logic             dav_oe_o,
  input  wire logic        nrfd_n_i,
  output logic             nrfd_n_o,
  output logic             nrfd_oe_o,
  input  wire logic        ndac_n_i,
  output logic             ndac_n_o,
  output logic             ndac_oe_o,
  output logic             atn_n_o,
  output logic             ifc_n_o,
  output logic             ren_n_o,
  input  wire logic        srq_n_i
);
  import gpc_pkg::*;
  localparam int unsigned SET_CYC = (`GPC_T_SETTLE_NS + `GPC_CLK_NS - 1) / `GPC_CLK_NS;
  localparam int unsigned IFC_CYC = (IFC_NS + `GPC_CLK_NS - 1) / `GPC_CLK_NS;

  logic [12:0] pin_s;
  logic        ack_r, ren_r, listen_r, rx_valid_r, rx_eoi_r, refused_r, sent_lis_r;
  logic [31:0] dat_r;
  logic [4:0]  addr_r;
  logic [7:0]  rx_byte_r;
  logic [15:0] cnt_r;
  gpc_tx_e     tx_st_r;
  gpc_rx_e     rx_st_r;
  gpc_op_e     op_r;
  logic [7:0]  dio_n_r;
  logic        dio_oe_r, eoi_n_r, eoi_oe_r, dav_n_r, dav_oe_r, nrfd_n_r, nrfd_oe_r;
  logic        ndac_n_r, ndac_oe_r, atn_n_r, ifc_n_r, ren_n_r;
  logic        wb_go, wr, ifc_go, tx_go, tx_start, rx_take, lis_act, idle;
  logic        cmd_atn, cmd_ok, eoi_t, dav_t, nrfd_t, ndac_t, srq_t;
  logic [7:0]  cmd_byte, byte_in;
  gpc_op_e     tx_op;

  gpc_sync #(.W(13)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({srq_n_i, ndac_n_i, nrfd_n_i, dav_n_i, eoi_n_i, dio_n_i}),
    .q_o   (pin_s)
  );

  // low level on a line means true
  assign byte_in  = ~pin_s[7:0];
  assign eoi_t    = ~pin_s[8];
  assign dav_t    = ~pin_s[9];
  assign nrfd_t   = ~pin_s[10];
  assign ndac_t   = ~pin_s[11];
  assign srq_t    = ~pin_s[12];
  assign idle     = (tx_st_r == T_IDLE);
  assign wb_go    = cyc_i & stb_i & ~ack_r;
  assign wr       = wb_go & we_i;
  assign ifc_go   = wr & (adr_i == `GPC_OFF_CTRL) & sel_i[0] & dat_i[`GPC_CTRL_IFC];
  assign tx_op    = gpc_op_e'(dat_i[15:12]);
  assign tx_go    = wr & (adr_i == `GPC_OFF_TX) & (&sel_i[1:0]);
  assign tx_start = tx_go & idle & cmd_ok;
  assign lis_act  = listen_r & atn_n_r & idle;
  assign rx_take  = lis_act & (rx_st_r == R_WAIT) & dav_t & ~nrfd_oe_r & ~rx_valid_r;

  // byte and attention level for each order
  always_comb
  begin
    cmd_byte = dat_i[7:0];
    cmd_atn  = 1'b1;
    cmd_ok   = 1'b1;
    case (tx_op)
      OP_RAW:
      begin
        cmd_atn = dat_i[`GPC_TX_ATN];
        cmd_ok  = ~(dat_i[`GPC_TX_ATN] & (dat_i[6:5] == 2'h3));
      end
      OP_LISTEN:    cmd_byte = `GPC_LISTEN_BASE | {3'h0, addr_r};
      OP_TALK:      cmd_byte = `GPC_TALK_BASE | {3'h0, addr_r};
      OP_UNLISTEN:  cmd_byte = `GPC_CMD_UNLISTEN;
      OP_UNTALK:    cmd_byte = `GPC_CMD_UNTALK;
      OP_LOCKOUT:   cmd_byte = `GPC_CMD_LOCKOUT;
      OP_ALL_CLEAR: cmd_byte = `GPC_CMD_ALL_CLEAR;
      OP_POLL_ON:   cmd_byte = `GPC_CMD_POLL_ON;
      OP_POLL_OFF:  cmd_byte = `GPC_CMD_POLL_OFF;
      OP_SEL_CLEAR:
      begin
        cmd_byte = `GPC_CMD_SEL_CLEAR;
        cmd_ok   = sent_lis_r;
      end
      OP_TO_LOCAL:
      begin
        cmd_byte = `GPC_CMD_TO_LOCAL;
        cmd_ok   = sent_lis_r;
      end
      OP_TRIGGER:   cmd_byte = `GPC_CMD_TRIGGER;
      default:      cmd_ok = 1'b0;
    endcase
  end

  // wishbone slave: ack one cycle after the request, reads registered
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end
    else
    begin
      ack_r <= wb_go;
      if (wb_go & ~we_i)
      begin
        case (adr_i)
          `GPC_OFF_CTRL: dat_r <= {19'h0, addr_r, 5'h0, listen_r, 1'b0, ren_r};
          `GPC_OFF_RX:   dat_r <= {22'h0, rx_valid_r, rx_eoi_r, rx_byte_r};
          `GPC_OFF_STAT: dat_r <= {28'h0, refused_r, rx_valid_r, srq_t, ~idle};
          default:       dat_r <= 32'h0;
        endcase
      end
    end
  end

  // software settings and sticky flags, set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ren_r      <= 1'b0;
      listen_r   <= 1'b0;
      addr_r     <= `GPC_ADDR_RESET;
      refused_r  <= 1'b0;
      sent_lis_r <= 1'b0;
      op_r       <= OP_RAW;
    end
    else
    begin
      if (wr & (adr_i == `GPC_OFF_CTRL) & sel_i[0])
      begin
        ren_r    <= dat_i[`GPC_CTRL_REN];
        listen_r <= dat_i[`GPC_CTRL_LISTEN];
      end
      if (wr & (adr_i == `GPC_OFF_CTRL) & sel_i[1])
        addr_r <= dat_i[12:8];
      if (tx_go & ~tx_start)
        refused_r <= 1'b1;
      else if (wr & (adr_i == `GPC_OFF_STAT) & sel_i[0] & dat_i[`GPC_STAT_REFUSED])
        refused_r <= 1'b0;
      if (tx_start)
        op_r <= tx_op;
      if (ifc_go | (tx_start & (tx_op == OP_UNLISTEN)))
        sent_lis_r <= 1'b0;
      else if (tx_start & (tx_op == OP_LISTEN))
        sent_lis_r <= 1'b1;
    end
  end

  // source handshake sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_st_r <= T_IDLE;
      cnt_r   <= 16'h0;
    end
    else if (ifc_go)
    begin
      tx_st_r <= T_IFC;
      cnt_r   <= 16'(IFC_CYC - 1);
    end
    else
    begin
      case (tx_st_r)
        T_IDLE:
          if (tx_start)
          begin
            tx_st_r <= T_SETTLE;
            cnt_r   <= 16'(SET_CYC - 1);
          end
        T_IFC, T_SETTLE:
          if (cnt_r == 16'h0)
            tx_st_r <= (tx_st_r == T_IFC) ? T_IDLE : T_READY;
          else
            cnt_r <= cnt_r - 16'h1;
        T_READY:
          if (~nrfd_t & ndac_t)
            tx_st_r <= T_VALID;
        T_VALID:
          if (~ndac_t)
            tx_st_r <= T_DONE;
        T_DONE:  tx_st_r <= T_IDLE;
        default: tx_st_r <= T_IDLE;
      endcase
    end
  end

  // controller-owned lines and source drive
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dio_n_r  <= 8'hFF;
      dio_oe_r <= 1'b0;
      eoi_n_r  <= 1'b1;
      eoi_oe_r <= 1'b0;
      dav_n_r  <= 1'b1;
      dav_oe_r <= 1'b0;
      atn_n_r  <= 1'b1;
      ifc_n_r  <= 1'b1;
      ren_n_r  <= 1'b1;
    end
    else
    begin
      ren_n_r <= ~ren_r;
      if (ifc_go | (tx_st_r == T_VALID & ~ndac_t))
      begin
        dav_n_r  <= 1'b1;
        dav_oe_r <= 1'b0;
        dio_n_r  <= 8'hFF;
        dio_oe_r <= 1'b0;
        eoi_n_r  <= 1'b1;
        eoi_oe_r <= 1'b0;
      end
      if (ifc_go)
        ifc_n_r <= 1'b0;
      else if (tx_st_r == T_IFC & cnt_r == 16'h0)
        ifc_n_r <= 1'b1;
      if (tx_start)
      begin
        atn_n_r  <= ~cmd_atn;
        dio_n_r  <= ~cmd_byte;
        dio_oe_r <= 1'b1;
        eoi_n_r  <= ~(dat_i[`GPC_TX_EOI] & ~cmd_atn);
        eoi_oe_r <= dat_i[`GPC_TX_EOI] & ~cmd_atn;
      end
      else if (idle & listen_r)
        atn_n_r <= 1'b1;
      if (tx_st_r == T_READY & ~nrfd_t & ndac_t & ~ifc_go)
      begin
        dav_n_r  <= 1'b0;
        dav_oe_r <= 1'b1;
      end
    end
  end

  // acceptor handshake while the instrument talks
  always_ff @(posedge clk_i)
  begin
    if (rst_i | ~lis_act)
    begin
      rx_st_r   <= R_WAIT;
      nrfd_n_r  <= 1'b1;
      nrfd_oe_r <= 1'b0;
      ndac_n_r  <= 1'b1;
      ndac_oe_r <= 1'b0;
    end
    else
    begin
      case (rx_st_r)
        R_WAIT:
          if (rx_take)
          begin
            rx_st_r   <= R_HELD;
            nrfd_n_r  <= 1'b0;
            nrfd_oe_r <= 1'b1;
            ndac_n_r  <= 1'b1;
            ndac_oe_r <= 1'b0;
          end
          else
          begin
            nrfd_n_r  <= ~rx_valid_r;
            nrfd_oe_r <= rx_valid_r;
            ndac_n_r  <= 1'b0;
            ndac_oe_r <= 1'b1;
          end
        R_HELD:
          if (~dav_t)
          begin
            rx_st_r   <= R_WAIT;
            ndac_n_r  <= 1'b0;
            ndac_oe_r <= 1'b1;
          end
        default: rx_st_r <= R_WAIT;
      endcase
    end
  end

  // received byte; a new byte beats a read in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_valid_r <= 1'b0;
      rx_byte_r  <= 8'h00;
      rx_eoi_r   <= 1'b0;
    end
    else if (rx_take)
    begin
      rx_valid_r <= 1'b1;
      rx_byte_r  <= byte_in;
      rx_eoi_r   <= eoi_t;
    end
    else if (wb_go & ~we_i & (adr_i == `GPC_OFF_RX))
      rx_valid_r <= 1'b0;
  end

  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign dio_n_o = dio_n_r;
  assign dio_oe_o = dio_oe_r;
  assign eoi_n_o = eoi_n_r;
  assign eoi_oe_o = eoi_oe_r;
  assign dav_n_o = dav_n_r;
  assign dav_oe_o = dav_oe_r;
  assign nrfd_n_o = nrfd_n_r;
  assign nrfd_oe_o = nrfd_oe_r;
  assign ndac_n_o = ndac_n_r;
  assign ndac_oe_o = ndac_oe_r;
  assign atn_n_o = atn_n_r;
  assign ifc_n_o = ifc_n_r;
  assign ren_n_o = ren_n_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_dav_after_ready: assert property ($fell(dav_n_r) |-> ~$past(nrfd_t) & $past(ndac_t))
    else $error("data valid asserted before all acceptors ready");
  chk_dio_stable: assert property (~dav_n_r & ~$past(dav_n_r) |-> $stable(dio_n_r))
    else $error("data lines changed while data valid");
  chk_atn_cmd_hold: assert property ($fell(dav_n_r) & (op_r != OP_RAW) |-> ~atn_n_r [*2])
    else $error("attention not held around command byte");
  chk_listen_byte: assert property ($fell(dav_n_r) & (op_r == OP_LISTEN)
    |-> dio_n_r == ~(`GPC_LISTEN_BASE | {3'h0, addr_r}))
    else $error("listen address byte malformed");
  chk_talk_byte: assert property ($fell(dav_n_r) & (op_r == OP_TALK)
    |-> dio_n_r == ~(`GPC_TALK_BASE | {3'h0, addr_r}))
    else $error("talk address byte malformed");
  chk_eoi_with_byte: assert property (eoi_oe_r |-> dio_oe_r & atn_n_r)
    else $error("end-or-identify without a data byte");
  chk_ifc_width: assert property ($rose(ifc_n_r) |-> $past(cnt_r) == 16'h0 & $past(tx_st_r) == T_IFC)
    else $error("interface clear released early");
  chk_ren_follows: assert property ($changed(ren_r) |=> ren_n_r == ~ren_r)
    else $error("remote enable line not following setting");
  chk_data_no_atn: assert property ($rose(rx_valid_r) |-> $past(atn_n_r, 2))
    else $error("byte taken as data while attention true");
  chk_ack_pulse: assert property (ack_r |=> ~ack_r)
    else $error("bus ack longer than one cycle");

  cov_cmd_byte: cover property ($fell(dav_n_r) & ~atn_n_r);
  cov_data_eoi: cover property ($fell(dav_n_r) & eoi_oe_r);
  cov_rx_byte: cover property ($rose(rx_valid_r));
  cov_ifc: cover property ($rose(ifc_n_r));
endmodule // gpc_ctrl
`default_nettype wire

// ===== include/gpc_cfg.svh
// register offsets, field positions, command codes and timing of the bus controller
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH
`define GPC_OFF_CTRL      8'h00
`define GPC_OFF_TX        8'h04
`define GPC_OFF_RX        8'h08
`define GPC_OFF_STAT      8'h0C
`define GPC_CTRL_REN      0
`define GPC_CTRL_IFC      1
`define GPC_CTRL_LISTEN   2
`define GPC_TX_ATN        8
`define GPC_TX_EOI        9
`define GPC_RX_EOI        8
`define GPC_RX_VALID      9
`define GPC_STAT_BUSY     0
`define GPC_STAT_SRQ      1
`define GPC_STAT_RXV      2
`define GPC_STAT_REFUSED  3
`define GPC_ADDR_RESET    5'h00
`define GPC_LISTEN_BASE   8'h20
`define GPC_TALK_BASE     8'h40
`define GPC_CMD_TO_LOCAL  8'h01
`define GPC_CMD_SEL_CLEAR 8'h04
`define GPC_CMD_TRIGGER   8'h08
`define GPC_CMD_LOCKOUT   8'h11
`define GPC_CMD_ALL_CLEAR 8'h14
`define GPC_CMD_POLL_ON   8'h18
`define GPC_CMD_POLL_OFF  8'h19
`define GPC_CMD_UNLISTEN  8'h3F
`define GPC_CMD_UNTALK    8'h5F
`define GPC_CLK_NS        4
`define GPC_T_SETTLE_NS   100
`define GPC_T_IFC_NS      100000
`endif

// ===== include/gpc_pkg.sv
// types of the bus controller
package gpc_pkg;
  typedef enum logic [3:0] {
    OP_RAW, OP_LISTEN, OP_TALK, OP_UNLISTEN, OP_UNTALK, OP_LOCKOUT, OP_ALL_CLEAR,
    OP_POLL_ON, OP_POLL_OFF, OP_SEL_CLEAR, OP_TO_LOCAL, OP_TRIGGER
  } gpc_op_e;
  typedef enum logic [2:0] {T_IDLE, T_IFC, T_SETTLE, T_READY, T_VALID, T_DONE} gpc_tx_e;
  typedef enum logic {R_WAIT, R_HELD} gpc_rx_e;
endpackage

// ===== rtl/gpc_sync.sv
// three-stage pin synchroniser, output changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module gpc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r <= {W{1'b1}};
      s2_r <= {W{1'b1}};
      s3_r <= {W{1'b1}};
      q_r  <= {W{1'b1}};
    end
    else
    begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= (s2_r & s3_r) | (q_r & (s2_r | s3_r));
    end
  end

  assign q_o = q_r;
endmodule // gpc_sync
`default_nettype wire

// ===== sim/gpc_inst_model.sv
// behavioural instrument on the far side of the bus: acceptor and command decoder
`timescale 1ns/10ps
`default_nettype none
module gpc_inst_model #(
  parameter logic [4:0] ADDR = 5'h05
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       atn_n_i,
  input  wire logic       ifc_n_i,
  input  wire logic       ren_n_i,
  input  wire logic [7:0] dio_n_i,
  input  wire logic       dav_n_i,
  input  wire logic       eoi_n_i,
  input  wire logic       slow_i,
  input  wire logic       srq_req_i,
  output logic            nrfd_n_o,
  output logic            ndac_n_o,
  output logic            srq_n_o,
  output logic      [6:0] st_o,
  output logic      [7:0] cnt_o,
  output logic      [7:0] byte_o
);
  logic [1:0] ph_r;
  logic [3:0] dly_r;
  logic       ren_q_r;
  assign srq_n_o = ~srq_req_i;
  always_ff @(posedge clk_i)
  begin
    ren_q_r <= ren_n_i;
    if (dly_r != 4'h0)
      dly_r <= dly_r - 4'h1;
    if (ren_n_i)
      st_o[2] <= 1'b0;
    else if (ren_q_r)
      st_o[2] <= 1'b1;
    case (ph_r)
      2'h0:
        if (!dav_n_i)
        begin
          nrfd_n_o <= 1'b0;
          byte_o <= ~dio_n_i;
          st_o[6] <= ~atn_n_i;
          st_o[5] <= ~eoi_n_i & atn_n_i;
          dly_r <= slow_i ? 4'hC : 4'h0;
          ph_r <= 2'h1;
          if (!atn_n_i)
            case (~dio_n_i)
              8'h3F: st_o[0] <= 1'b0;
              8'h5F: st_o[1] <= 1'b0;
              8'h11: st_o[3] <= 1'b1;
              8'h14: cnt_o[3:0] <= cnt_o[3:0] + 4'h1;
              8'h18: st_o[4] <= 1'b1;
              8'h19: st_o[4] <= 1'b0;
              8'h04: cnt_o[3:0] <= cnt_o[3:0] + {3'h0, st_o[0]};
              8'h01: st_o[2] <= st_o[2] & ~st_o[0];
              8'h08: cnt_o[7:4] <= cnt_o[7:4] + 4'h1;
              {3'b001, ADDR}: st_o[0] <= 1'b1;
              {3'b010, ADDR}: st_o[1] <= 1'b1;
              default: ;
            endcase
        end
      2'h1:
        if (dly_r == 4'h0)
        begin
          ndac_n_o <= 1'b1;
          ph_r <= 2'h2;
        end
      2'h2:
        if (dav_n_i)
        begin
          ndac_n_o <= 1'b0;
          dly_r <= slow_i ? 4'hC : 4'h0;
          ph_r <= 2'h3;
        end
      default:
        if (dly_r == 4'h0)
        begin
          nrfd_n_o <= 1'b1;
          ph_r <= 2'h0;
        end
    endcase
    if (!ifc_n_i)
      st_o[1:0] <= 2'h0;
    if (rst_i)
    begin
      st_o <= 7'h0;
      cnt_o <= 8'h0;
      byte_o <= 8'h0;
      nrfd_n_o <= 1'b1;
      ndac_n_o <= 1'b0;
      ph_r <= 2'h0;
      dly_r <= 4'h0;
    end
  end
endmodule // gpc_inst_model
`default_nettype wire

// ===== sim/tb_gpc_ctrl.sv
// self-checking bench: controller over wishbone against the instrument model
`timescale 1ns/10ps
`default_nettype none
`include "gpc_cfg.svh"
module tb_gpc_ctrl;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, q;
  logic [7:0]  dio_n_o, cnt, rx_byte;
  logic [6:0]  st;
  logic        ack_o, dio_oe_o, eoi_n_o, eoi_oe_o, dav_n_o, dav_oe_o;
  logic        nrfd_n_o, nrfd_oe_o, ndac_n_o, ndac_oe_o, atn_n_o, ifc_n_o, ren_n_o;
  logic        m_nrfd, m_ndac, srq_n;
  logic        slow = 1'b0;
  logic        srq_req = 1'b0;
  logic [7:0]  t_dio = 8'hFF;
  logic        t_eoi = 1'b1;
  logic        t_dav = 1'b1;
  int          fails = 0;
  int          n_tests = 0;
  wire logic [7:0] dio_w = t_dio & (dio_oe_o ? dio_n_o : 8'hFF);
  wire logic   eoi_w = t_eoi & (eoi_oe_o ? eoi_n_o : 1'b1);
  wire logic   dav_w = t_dav & (dav_oe_o ? dav_n_o : 1'b1);
  wire logic   nrfd_w = m_nrfd & (nrfd_oe_o ? nrfd_n_o : 1'b1);
  wire logic   ndac_w = m_ndac & (ndac_oe_o ? ndac_n_o : 1'b1);
  gpc_ctrl #(.IFC_NS(200)) i_gpc_ctrl (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .dio_n_i(dio_w), .dio_n_o, .dio_oe_o, .eoi_n_i(eoi_w), .eoi_n_o, .eoi_oe_o,
    .dav_n_i(dav_w), .dav_n_o, .dav_oe_o, .nrfd_n_i(nrfd_w), .nrfd_n_o, .nrfd_oe_o,
    .ndac_n_i(ndac_w), .ndac_n_o, .ndac_oe_o, .atn_n_o, .ifc_n_o, .ren_n_o, .srq_n_i(srq_n)
  );
  gpc_inst_model i_gpc_inst_model (
    .clk_i, .rst_i, .atn_n_i(atn_n_o), .ifc_n_i(ifc_n_o), .ren_n_i(ren_n_o), .dio_n_i(dio_w),
    .dav_n_i(dav_w), .eoi_n_i(eoi_w), .slow_i(slow), .srq_req_i(srq_req), .nrfd_n_o(m_nrfd),
    .ndac_n_o(m_ndac), .srq_n_o(srq_n), .st_o(st), .cnt_o(cnt), .byte_o(rx_byte)
  );
  always #2 clk_i = ~clk_i;
  task automatic end_sim;
    if (fails == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'hF;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1)
      @(posedge clk_i);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  // op plus {eoi, atn, byte}, then poll busy until the byte is done
  task automatic send(input logic [3:0] op, input logic [9:0] b);
    wb(`GPC_OFF_TX, 1'b1, {16'h0, op, 2'b00, b});
    q = 32'h1;
    while (q[0] !== 1'b0)
      wb(`GPC_OFF_STAT, 1'b0, 32'h0);
  endtask
  // instrument talks one data byte with end flag, controller listens
  task automatic t_listen;
    wb(`GPC_OFF_CTRL, 1'b1, 32'h0505);
    t_dio <= ~8'h3A;
    t_eoi <= 1'b0;
    repeat (4) @(posedge clk_i);
    while (nrfd_w !== 1'b1 || ndac_w !== 1'b0)
      @(posedge clk_i);
    t_dav <= 1'b0;
    @(posedge clk_i);
    while (ndac_w !== 1'b1)
      @(posedge clk_i);
    t_dav <= 1'b1;
    t_dio <= 8'hFF;
    t_eoi <= 1'b1;
    @(posedge clk_i);
    while (ndac_w !== 1'b0)
      @(posedge clk_i);
    repeat (8) @(posedge clk_i);
    chk("acc hold", 32'hA, {nrfd_oe_o, nrfd_n_o, ndac_oe_o, ndac_n_o});
    wb(`GPC_OFF_STAT, 1'b0, 32'h0);
    chk("rx stat", 32'h4, q);
    wb(`GPC_OFF_RX, 1'b0, 32'h0);
    chk("rx byte", 32'h33A, q);
    wb(`GPC_OFF_RX, 1'b0, 32'h0);
    chk("rx empty", 32'h13A, q);
    repeat (2) @(posedge clk_i);
    chk("nrfd free", 32'h0, nrfd_oe_o);
    wb(`GPC_OFF_CTRL, 1'b1, 32'h0501);
  endtask
  task automatic t_reset;
    wb(`GPC_OFF_CTRL, 1'b0, 32'h0);
    chk("ctrl", 32'h0, q);
    wb(`GPC_OFF_STAT, 1'b0, 32'h0);
    chk("stat", 32'h0, q);
    wb(8'h40, 1'b1, 32'hFFFF_FFFF);
    wb(8'h40, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("lines", 32'h7, {atn_n_o, ifc_n_o, ren_n_o});
  endtask
  task automatic t_addr;
    wb(`GPC_OFF_CTRL, 1'b1, 32'h0501);
    repeat (2) @(posedge clk_i);
    chk("ren", 32'h0, ren_n_o);
    chk("remote", 32'h1, st[2]);
    send(4'h1, 10'h0);
    chk("lsn byte", 32'h25, rx_byte);
    chk("listen", 32'h1, st[0]);
    chk("atn", 32'h1, st[6]);
    send(4'h2, 10'h0);
    chk("tlk byte", 32'h45, rx_byte);
    chk("talk", 32'h1, st[1]);
    send(4'h3, 10'h0);
    chk("unlisten", 32'h0, st[0]);
    send(4'h4, 10'h0);
    chk("untalk", 32'h0, st[1]);
    wb(`GPC_OFF_CTRL, 1'b1, 32'h1F01);
    send(4'h1, 10'h0);
    chk("addr 31", 32'h3F, rx_byte);
    wb(`GPC_OFF_CTRL, 1'b1, 32'h0501);
  endtask
  task automatic t_univ;
    send(4'h5, 10'h0);
    chk("lockout", 32'h1, st[3]);
    send(4'h7, 10'h0);
    chk("poll on", 32'h1, st[4]);
    send(4'h8, 10'h0);
    chk("poll off", 32'h0, st[4]);
    send(4'h6, 10'h0);
    chk("clear", 32'h1, cnt[3:0]);
    send(4'hB, 10'h0);
    chk("trigger", 32'h1, cnt[7:4]);
  endtask
  task automatic t_addrd;
    send(4'h3, 10'h0);
    send(4'h9, 10'h0);
    wb(`GPC_OFF_STAT, 1'b0, 32'h0);
    chk("refused", 32'h8, q);
    chk("no clear", 32'h1, cnt[3:0]);
    wb(`GPC_OFF_STAT, 1'b1, 32'h8);
    wb(`GPC_OFF_STAT, 1'b0, 32'h0);
    chk("unrefused", 32'h0, q);
    send(4'h1, 10'h0);
    send(4'h9, 10'h0);
    chk("sel clear", 32'h2, cnt[3:0]);
    send(4'hA, 10'h0);
    chk("local", 32'h0, st[2]);
  endtask
  task automatic t_raw;
    send(4'h0, 10'h165);
    wb(`GPC_OFF_STAT, 1'b0, 32'h0);
    chk("secondary", 32'h8, q);
    wb(`GPC_OFF_STAT, 1'b1, 32'h8);
    send(4'h0, 10'h108);
    chk("raw trig", 32'h2, cnt[7:4]);
    send(4'h0, 10'h115);
    chk("unknown", 32'h2, cnt[7:4]);
    slow <= 1'b1;
    send(4'h0, 10'h22A);
    chk("data", 32'h2A, rx_byte);
    chk("end flag", 32'h1, st[5]);
    chk("data atn", 32'h0, st[6]);
    send(4'h0, 10'h0D5);
    chk("no end", 32'h0, st[5]);
    slow <= 1'b0;
  endtask
  task automatic t_ifc;
    int n;
    n = 0;
    send(4'h1, 10'h0);
    wb(`GPC_OFF_CTRL, 1'b1, 32'h0503);
    while (ifc_n_o !== 1'b0 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (ifc_n_o === 1'b0 && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("ifc len", 32'd50, n);
    chk("ifc idle", 32'h0, st[1:0]);
  endtask
  task automatic t_srq;
    srq_req <= 1'b1;
    repeat (8) @(posedge clk_i);
    wb(`GPC_OFF_STAT, 1'b0, 32'h0);
    chk("srq on", 32'h1, q[1]);
    srq_req <= 1'b0;
    repeat (8) @(posedge clk_i);
    wb(`GPC_OFF_STAT, 1'b0, 32'h0);
    chk("srq off", 32'h0, q[1]);
  endtask
  initial
  begin
    #200000;
    fails++;
    end_sim;
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_addr;
    t_univ;
    t_addrd;
    t_raw;
    t_listen;
    t_ifc;
    t_srq;
    end_sim;
  end
endmodule // tb_gpc_ctrl
`default_nettype wire
